// ---- hdl/otd_defines.vh ----
// shared constants of the operand type datapath
`ifndef OTD_DEFINES_VH
`define OTD_DEFINES_VH

// --------------------------------------------------------------------
// operation codes on op_code
// --------------------------------------------------------------------
`define OTD_OP_ADD      5'h00
`define OTD_OP_SUB      5'h01
`define OTD_OP_COMPARE  5'h02
`define OTD_OP_AND      5'h03
`define OTD_OP_OR       5'h04
`define OTD_OP_XOR      5'h05
`define OTD_OP_LD_ZFILL 5'h06
`define OTD_OP_LD_SFILL 5'h07
`define OTD_OP_ZERO_WRD 5'h08
`define OTD_OP_WIDEN_SW 5'h09
`define OTD_OP_SHL32    5'h0a
`define OTD_OP_SHR32    5'h0b
`define OTD_OP_SRA32    5'h0c
`define OTD_OP_MUL      5'h0d
`define OTD_OP_DIV      5'h0e
`define OTD_OP_NORM     5'h0f
`define OTD_OP_LD_WORD  5'h10
`define OTD_OP_PUSH32   5'h11
`define OTD_OP_BLK_CHK  5'h12
`define OTD_OP_BR_ABOVE 5'h13
`define OTD_OP_BR_GREAT 5'h14
`define OTD_OP_BR_BCLR  5'h15
`define OTD_OP_BR_BSET  5'h16

// --------------------------------------------------------------------
// shifter modes
// --------------------------------------------------------------------
`define OTD_SH_LEFT     2'h0
`define OTD_SH_RIGHT    2'h1
`define OTD_SH_ARITH    2'h2
`define OTD_SH_NORM     2'h3

// --------------------------------------------------------------------
// placement, byte lanes, counts and reset values
// --------------------------------------------------------------------
`define OTD_LRF_TOP     16'h0100
`define OTD_BE_LOW      2'h1
`define OTD_BE_HIGH     2'h2
`define OTD_BE_WORD     2'h3
`define OTD_DIV_STEPS   5'h10
`define OTD_RST_WORD    16'h0000
`define OTD_RST_RESULT  32'h00000000
`define OTD_RST_FLAG    1'b0
`define OTD_RST_CNT     5'h00
`define OTD_RST_LANE    2'h0

`endif

// ---- hdl/otd_addsub.v ----
// byte or word adder/subtractor with carry, overflow, zero and sign flags
`timescale 1ns/100ps
module otd_addsub (
	input  wire [15:0] a,        // first operand
	input  wire [15:0] b,        // second operand
	input  wire        sub,      // high: a minus b
	input  wire        is_byte,  // high: operate on the low byte only
	output reg  [15:0] sum,      // wrapped result, upper byte zero for bytes
	output reg         carry,    // carry out, or no-borrow on subtract
	output reg         ovf,      // signed result out of range
	output reg         zero,     // result is zero
	output reg         neg       // sign bit of result
);

	reg [16:0] wide;
	reg [15:0] bx;

	// --------------------------------------------------------------------
	// one path for signed and unsigned; flags allow either reading later
	// --------------------------------------------------------------------
	always @*
	begin
		wide = 17'h00000;
		bx   = sub ? ~b : b;
		sum  = 16'h0000;
		if (is_byte)
		begin
			wide  = {9'h000, a[7:0]} + {9'h000, bx[7:0]} + {16'h0000, sub};
			sum   = {8'h00, wide[7:0]};
			carry = wide[8];
			ovf   = (a[7] == bx[7]) && (wide[7] != a[7]);
			neg   = wide[7];
		end
		else
		begin
			wide  = {1'b0, a} + {1'b0, bx} + {16'h0000, sub};
			sum   = wide[15:0];
			carry = wide[16];
			ovf   = (a[15] == bx[15]) && (wide[15] != a[15]);
			neg   = wide[15];
		end
		zero = (sum == 16'h0000);
	end

endmodule

// ---- hdl/otd_shifter.v ----
// 32-bit shifter with carry and rounding residue, plus normalize
`timescale 1ns/100ps
`include "otd_defines.vh"
module otd_shifter (
	input  wire [31:0] val,      // 32-bit operand
	input  wire [4:0]  amt,      // shift count
	input  wire [1:0]  mode,     // left, right, arithmetic, normalize
	output reg  [31:0] res,      // shifted or normalized value
	output reg         carry,    // last bit shifted out
	output reg         sticky,   // or of the bits shifted out before the last on right shifts
	output reg  [4:0]  cnt       // normalize shift count
);

	reg [32:0] lft;
	reg [63:0] rgt;

	// count of leading zeros; a zero value gives 31 so the shift stays in range
	function [4:0] otd_lead_cnt;
		input [31:0] v;
		integer i;
		begin
			otd_lead_cnt = 5'h1f;
			for (i = 0; i < 32; i = i + 1)
				if (v[i])
					otd_lead_cnt = 5'h1f - i[4:0];
		end
	endfunction

	// --------------------------------------------------------------------
	// right shifts keep the last lost bit and an or of the others so a later rounding step can use them
	// --------------------------------------------------------------------
	always @*
	begin
		lft    = {1'b0, val} << amt;
		rgt    = {val, 32'h00000000} >> amt;
		res    = val;
		carry  = 1'b0;
		sticky = 1'b0;
		cnt    = 5'h00;
		case (mode)
			`OTD_SH_LEFT:
			begin
				res   = lft[31:0];
				carry = (amt == 5'h00) ? 1'b0 : lft[32];
			end
			`OTD_SH_RIGHT, `OTD_SH_ARITH:
			begin
				if (mode == `OTD_SH_ARITH)
					rgt = $signed({val, 32'h00000000}) >>> amt;
				res    = rgt[63:32];
				carry  = rgt[31];
				sticky = |rgt[30:0];
			end
			default:
			begin
				cnt = otd_lead_cnt(val);
				res = val << cnt;
			end
		endcase
	end

endmodule

// ---- hdl/otd_datapath.v ----
// operand type datapath: byte/word arithmetic, 32-bit ops, loads and branches
//
// Behaviour
// - byte arithmetic wraps modulo 256; byte logic works on each bit alone.
// - signed byte result outside -128..+127 sets overflow flags; value as unsigned.
// - signed word result outside -32768..+32767 sets overflow flags; value as unsigned.
// - word arithmetic wraps modulo 65536; word logic works bit by bit.
// - bits numbered 0..7 in bytes, 0..15 in words, bit 0 least significant.
// - word low byte at even address, high byte at next odd address.
// - bytes, signed or unsigned, are accepted at any address.
// - 32-bit operands only for shifts, normalize, 32/16 divide and 16x16 product.
// - 32-bit values keep low word at lower address; high word pushed first.
// - 64-bit operands only for block move, lower register file, divisible by eight.
// - zero-fill byte load clears upper byte; zero word op clears upper word.
// - sign-fill byte load and word widen copy the sign bit upward.
// - add, subtract and compare share one path for signed and unsigned.
// - above branch reads flags unsigned, greater branch reads them signed.
// - bits reached only inside bytes or words; bit branches test one bit.
// - normalize a 32-bit value; residue flag aids rounding with carry.
`timescale 1ns/100ps
`include "otd_defines.vh"
module otd_datapath (
	input  wire        ref_clk,      // core clock, 40 MHz
	input  wire        rst,          // synchronous reset, active high
	input  wire        op_start,     // one-cycle request, taken when not busy
	input  wire [4:0]  op_code,      // operation code
	input  wire        is_byte,      // byte size for add, sub, compare, logic
	input  wire [15:0] opd_a,        // first 16-bit operand
	input  wire [15:0] opd_b,        // second operand, shift count, bit number
	input  wire [31:0] opd_wide,     // 32-bit operand
	input  wire [15:0] opd_addr,     // operand address or stack pointer
	input  wire [15:0] mem_rdata,    // read word, sampled in the cycle mem_re_r is high
	output reg         busy_r,       // operation in progress
	output reg         done_r,       // one-cycle completion pulse
	output reg  [31:0] result_r,     // result value
	output reg  [4:0]  norm_cnt_r,   // normalize shift count
	output reg         branch_r,     // branch decision of last branch op
	output reg         align_err_r,  // last operand placement was unsupported
	output reg         flag_z_r,     // zero flag
	output reg         flag_n_r,     // negative flag
	output reg         flag_c_r,     // carry flag
	output reg         flag_v_r,     // overflow flag
	output reg         flag_vt_r,    // sticky overflow flag
	output reg         flag_st_r,    // rounding residue flag
	output reg  [15:0] mem_addr_r,   // word address to memory, forced even for loads only
	output reg  [15:0] mem_wdata_r,  // write word
	output reg  [1:0]  mem_be_r,     // byte lanes, bit 0 = even byte
	output reg         mem_we_r,     // write strobe, one cycle per word written, two back-to-back cycles for a push
	output reg         mem_re_r      // one-cycle read strobe
);

	// --------------------------------------------------------------------
	// states
	// --------------------------------------------------------------------
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_READ  = 4'h2;
	localparam [3:0] ST_DIV   = 4'h4;
	localparam [3:0] ST_PUSH2 = 4'h8;

	reg  [3:0]  state_r,     state_nxt;
	reg         busy_nxt,    done_nxt,     branch_nxt,   align_err_nxt;
	reg  [31:0] result_nxt;
	reg  [4:0]  norm_cnt_nxt;
	reg         flag_z_nxt,  flag_n_nxt,   flag_c_nxt;
	reg         flag_v_nxt,  flag_vt_nxt,  flag_st_nxt;
	reg  [15:0] mem_addr_nxt, mem_wdata_nxt;
	reg  [1:0]  mem_be_nxt;
	reg         mem_we_nxt,  mem_re_nxt;
	reg  [4:0]  op_hold_r,   op_hold_nxt;
	reg         lane_hi_r,   lane_hi_nxt;
	reg  [15:0] div_rem_r,   div_rem_nxt;
	reg  [15:0] div_quo_r,   div_quo_nxt;
	reg  [15:0] div_den_r,   div_den_nxt;
	reg  [4:0]  div_cnt_r,   div_cnt_nxt;
	reg  [15:0] push_lo_r,   push_lo_nxt;

	reg  [16:0] div_try;
	reg         div_ge;
	reg  [7:0]  rd_byte;
	reg  [1:0]  sh_mode;
	reg         is_sub;

	wire [15:0] as_sum;
	wire        as_c, as_v, as_z, as_n;
	wire [31:0] sh_res;
	wire        sh_c, sh_st;
	wire [4:0]  sh_cnt;

	// 32-bit operands must sit in the lower register file on a four-byte boundary
	function bad_place;
		input [15:0] adr;
		input [2:0]  mask;
		begin
			bad_place = ((adr[2:0] & mask) != 3'h0) || (adr >= `OTD_LRF_TOP);
		end
	endfunction

	// --------------------------------------------------------------------
	// arithmetic and shift units
	// --------------------------------------------------------------------
	otd_addsub u_addsub (
		.a       (opd_a),
		.b       (opd_b),
		.sub     (is_sub),
		.is_byte (is_byte),
		.sum     (as_sum),
		.carry   (as_c),
		.ovf     (as_v),
		.zero    (as_z),
		.neg     (as_n)
	);

	otd_shifter u_shifter (
		.val    (opd_wide),
		.amt    (opd_b[4:0]),
		.mode   (sh_mode),
		.res    (sh_res),
		.carry  (sh_c),
		.sticky (sh_st),
		.cnt    (sh_cnt)
	);

	// unit controls follow the op code directly
	always @*
	begin
		is_sub = (op_code == `OTD_OP_SUB) || (op_code == `OTD_OP_COMPARE);
		case (op_code)
			`OTD_OP_SHL32: sh_mode = `OTD_SH_LEFT;
			`OTD_OP_SHR32: sh_mode = `OTD_SH_RIGHT;
			`OTD_OP_SRA32: sh_mode = `OTD_SH_ARITH;
			default:       sh_mode = `OTD_SH_NORM;
		endcase
	end

	// --------------------------------------------------------------------
	// next-state logic
	// --------------------------------------------------------------------
	always @*
	begin
		state_nxt     = state_r;
		busy_nxt      = busy_r;
		done_nxt      = 1'b0;
		branch_nxt    = branch_r;
		align_err_nxt = align_err_r;
		result_nxt    = result_r;
		norm_cnt_nxt  = norm_cnt_r;
		flag_z_nxt    = flag_z_r;
		flag_n_nxt    = flag_n_r;
		flag_c_nxt    = flag_c_r;
		flag_v_nxt    = flag_v_r;
		flag_vt_nxt   = flag_vt_r;
		flag_st_nxt   = flag_st_r;
		mem_addr_nxt  = mem_addr_r;
		mem_wdata_nxt = mem_wdata_r;
		mem_be_nxt    = mem_be_r;
		mem_we_nxt    = 1'b0;
		mem_re_nxt    = 1'b0;
		op_hold_nxt   = op_hold_r;
		lane_hi_nxt   = lane_hi_r;
		div_rem_nxt   = div_rem_r;
		div_quo_nxt   = div_quo_r;
		div_den_nxt   = div_den_r;
		div_cnt_nxt   = div_cnt_r;
		push_lo_nxt   = push_lo_r;
		div_try       = {div_rem_r, div_quo_r[15]};
		div_ge        = (div_try >= {1'b0, div_den_r});
		rd_byte       = lane_hi_r ? mem_rdata[15:8] : mem_rdata[7:0];
		case (state_r)
			ST_IDLE:
			begin
				if (op_start)
				begin
					op_hold_nxt   = op_code;
					align_err_nxt = 1'b0;
					done_nxt      = 1'b1;
					case (op_code)
						`OTD_OP_ADD, `OTD_OP_SUB, `OTD_OP_COMPARE:
						begin
							// compare keeps the result and changes only flags
							if (op_code != `OTD_OP_COMPARE)
								result_nxt = {16'h0000, as_sum};
							flag_z_nxt  = as_z;
							flag_n_nxt  = as_n;
							flag_c_nxt  = as_c;
							flag_v_nxt  = as_v;
							flag_vt_nxt = flag_vt_r | as_v;
						end
						`OTD_OP_AND, `OTD_OP_OR, `OTD_OP_XOR:
						begin
							if (op_code == `OTD_OP_AND)
								result_nxt = {16'h0000, opd_a & opd_b};
							else if (op_code == `OTD_OP_OR)
								result_nxt = {16'h0000, opd_a | opd_b};
							else
								result_nxt = {16'h0000, opd_a ^ opd_b};
							if (is_byte)
								result_nxt[15:8] = 8'h00;
							flag_z_nxt = is_byte ? (result_nxt[7:0] == 8'h00)
							                     : (result_nxt[15:0] == 16'h0000);
							flag_n_nxt = is_byte ? result_nxt[7] : result_nxt[15];
							flag_c_nxt = 1'b0;
							flag_v_nxt = 1'b0;
						end
						`OTD_OP_LD_ZFILL, `OTD_OP_LD_SFILL, `OTD_OP_LD_WORD:
						begin
							// memory is a word array; the address bit picks the lane
							done_nxt     = 1'b0;
							busy_nxt     = 1'b1;
							mem_re_nxt   = 1'b1;
							mem_addr_nxt = {opd_addr[15:1], 1'b0};
							lane_hi_nxt  = opd_addr[0];
							if (op_code == `OTD_OP_LD_WORD)
							begin
								mem_be_nxt    = `OTD_BE_WORD;
								align_err_nxt = opd_addr[0];
							end
							else
								mem_be_nxt = opd_addr[0] ? `OTD_BE_HIGH : `OTD_BE_LOW;
							state_nxt = ST_READ;
						end
						`OTD_OP_ZERO_WRD:
							result_nxt = {16'h0000, opd_a};
						`OTD_OP_WIDEN_SW:
							result_nxt = {{16{opd_a[15]}}, opd_a};
						`OTD_OP_SHL32, `OTD_OP_SHR32, `OTD_OP_SRA32:
						begin
							result_nxt    = sh_res;
							align_err_nxt = bad_place(opd_addr, 3'h3);
							flag_z_nxt    = (sh_res == 32'h00000000);
							flag_n_nxt    = sh_res[31];
							flag_c_nxt    = sh_c;
							flag_v_nxt    = 1'b0;
							flag_st_nxt   = sh_st;
						end
						`OTD_OP_MUL:
						begin
							result_nxt    = opd_a * opd_b;
							align_err_nxt = bad_place(opd_addr, 3'h3);
						end
						`OTD_OP_DIV:
						begin
							align_err_nxt = bad_place(opd_addr, 3'h3);
							// a quotient wider than 16 bits or a zero divisor cannot be formed
							if (opd_wide[31:16] >= opd_b)
							begin
								flag_v_nxt  = 1'b1;
								flag_vt_nxt = 1'b1;
							end
							else
							begin
								done_nxt    = 1'b0;
								busy_nxt    = 1'b1;
								flag_v_nxt  = 1'b0;
								div_rem_nxt = opd_wide[31:16];
								div_quo_nxt = opd_wide[15:0];
								div_den_nxt = opd_b;
								div_cnt_nxt = `OTD_DIV_STEPS;
								state_nxt   = ST_DIV;
							end
						end
						`OTD_OP_NORM:
						begin
							result_nxt    = sh_res;
							norm_cnt_nxt  = sh_cnt;
							align_err_nxt = bad_place(opd_addr, 3'h3);
							flag_z_nxt    = (opd_wide == 32'h00000000);
						end
						`OTD_OP_PUSH32:
						begin
							// high word goes first so the low word lands lower
							done_nxt      = 1'b0;
							busy_nxt      = 1'b1;
							mem_we_nxt    = 1'b1;
							mem_be_nxt    = `OTD_BE_WORD;
							mem_addr_nxt  = opd_addr - 16'h0002;
							mem_wdata_nxt = opd_wide[31:16];
							push_lo_nxt   = opd_wide[15:0];
							align_err_nxt = opd_addr[0];
							state_nxt     = ST_PUSH2;
						end
						`OTD_OP_BLK_CHK:
							align_err_nxt = bad_place(opd_addr, 3'h7);
						`OTD_OP_BR_ABOVE:
							branch_nxt = flag_c_r & ~flag_z_r;
						`OTD_OP_BR_GREAT:
							branch_nxt = ~flag_z_r & ~(flag_n_r ^ flag_v_r);
						`OTD_OP_BR_BCLR:
							branch_nxt = ~opd_a[opd_b[3:0]];
						`OTD_OP_BR_BSET:
							branch_nxt = opd_a[opd_b[3:0]];
						default:
							align_err_nxt = 1'b0;
					endcase
				end
			end
			ST_READ:
			begin
				// read data is taken in the cycle the strobe is high
				case (op_hold_r)
					`OTD_OP_LD_ZFILL: result_nxt = {24'h000000, rd_byte};
					`OTD_OP_LD_SFILL: result_nxt = {16'h0000, {8{rd_byte[7]}}, rd_byte};
					default:          result_nxt = {16'h0000, mem_rdata};
				endcase
				busy_nxt  = 1'b0;
				done_nxt  = 1'b1;
				state_nxt = ST_IDLE;
			end
			ST_DIV:
			begin
				// restoring division, one quotient bit per cycle
				div_rem_nxt = div_ge ? (div_try[15:0] - div_den_r) : div_try[15:0];
				div_quo_nxt = {div_quo_r[14:0], div_ge};
				div_cnt_nxt = div_cnt_r - 5'h01;
				if (div_cnt_r == 5'h01)
				begin
					result_nxt = {div_rem_nxt, div_quo_nxt};
					busy_nxt   = 1'b0;
					done_nxt   = 1'b1;
					state_nxt  = ST_IDLE;
				end
			end
			ST_PUSH2:
			begin
				mem_we_nxt    = 1'b1;
				mem_addr_nxt  = mem_addr_r - 16'h0002;
				mem_wdata_nxt = push_lo_r;
				result_nxt    = {16'h0000, mem_addr_r - 16'h0002};
				busy_nxt      = 1'b0;
				done_nxt      = 1'b1;
				state_nxt     = ST_IDLE;
			end
			default:
			begin
				busy_nxt  = 1'b0;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------------
	// registers
	// --------------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_r     <= ST_IDLE;
			busy_r      <= `OTD_RST_FLAG;
			done_r      <= `OTD_RST_FLAG;
			branch_r    <= `OTD_RST_FLAG;
			align_err_r <= `OTD_RST_FLAG;
			result_r    <= `OTD_RST_RESULT;
			norm_cnt_r  <= `OTD_RST_CNT;
			flag_z_r    <= `OTD_RST_FLAG;
			flag_n_r    <= `OTD_RST_FLAG;
			flag_c_r    <= `OTD_RST_FLAG;
			flag_v_r    <= `OTD_RST_FLAG;
			flag_vt_r   <= `OTD_RST_FLAG;
			flag_st_r   <= `OTD_RST_FLAG;
			mem_addr_r  <= `OTD_RST_WORD;
			mem_wdata_r <= `OTD_RST_WORD;
			mem_be_r    <= `OTD_RST_LANE;
			mem_we_r    <= `OTD_RST_FLAG;
			mem_re_r    <= `OTD_RST_FLAG;
			op_hold_r   <= `OTD_RST_CNT;
			lane_hi_r   <= `OTD_RST_FLAG;
			div_rem_r   <= `OTD_RST_WORD;
			div_quo_r   <= `OTD_RST_WORD;
			div_den_r   <= `OTD_RST_WORD;
			div_cnt_r   <= `OTD_RST_CNT;
			push_lo_r   <= `OTD_RST_WORD;
		end
		else
		begin
			state_r     <= state_nxt;
			busy_r      <= busy_nxt;
			done_r      <= done_nxt;
			branch_r    <= branch_nxt;
			align_err_r <= align_err_nxt;
			result_r    <= result_nxt;
			norm_cnt_r  <= norm_cnt_nxt;
			flag_z_r    <= flag_z_nxt;
			flag_n_r    <= flag_n_nxt;
			flag_c_r    <= flag_c_nxt;
			flag_v_r    <= flag_v_nxt;
			flag_vt_r   <= flag_vt_nxt;
			flag_st_r   <= flag_st_nxt;
			mem_addr_r  <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			mem_be_r    <= mem_be_nxt;
			mem_we_r    <= mem_we_nxt;
			mem_re_r    <= mem_re_nxt;
			op_hold_r   <= op_hold_nxt;
			lane_hi_r   <= lane_hi_nxt;
			div_rem_r   <= div_rem_nxt;
			div_quo_r   <= div_quo_nxt;
			div_den_r   <= div_den_nxt;
			div_cnt_r   <= div_cnt_nxt;
			push_lo_r   <= push_lo_nxt;
		end
	end

endmodule

// ---- test/otd_checker.sv ----
// assertion checker bound to the operand type datapath
`timescale 1ns/100ps
`include "otd_defines.vh"
module otd_checker (
	input wire        ref_clk,     // clock
	input wire        rst,         // reset
	input wire        op_start,    // request
	input wire [4:0]  op_code,     // op
	input wire        is_byte,     // size
	input wire [15:0] opd_a,       // operand a
	input wire [15:0] opd_b,       // operand b
	input wire [31:0] opd_wide,    // wide operand
	input wire [15:0] opd_addr,    // address
	input wire        busy_r,      // busy
	input wire        done_r,      // done
	input wire [31:0] result_r,    // result
	input wire        branch_r,    // branch
	input wire        flag_z_r,    // zero
	input wire        flag_n_r,    // negative
	input wire        flag_c_r,    // carry
	input wire        flag_v_r,    // overflow
	input wire        flag_vt_r,   // sticky overflow
	input wire [15:0] mem_addr_r,  // address out
	input wire [15:0] mem_wdata_r, // write data
	input wire        mem_we_r,    // write strobe
	input wire        mem_re_r     // read strobe
);
// ------
// helpers
// ------
	// a request only counts when the datapath is idle
	wire        tk  = op_start && !busy_r;
	wire [15:0] sum = is_byte ? {8'h00, opd_a[7:0] + opd_b[7:0]} : opd_a + opd_b;
	wire [15:0] hi  = opd_wide[31:16];
	wire [15:0] lo  = opd_wide[15:0];
	wire        abv = flag_c_r && !flag_z_r;
	wire        gtr = !flag_z_r && (flag_n_r == flag_v_r);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
// ------
// properties
// ------
	a_add_wrap: assert property (
		tk && op_code == `OTD_OP_ADD |=> done_r && result_r[15:0] == $past(sum))
		else $error("add result wrong");
	a_vt_sticky: assert property (
		flag_v_r |-> flag_vt_r) else $error("sticky overflow missing");
	a_word_even: assert property (
		mem_re_r |-> !mem_addr_r[0]) else $error("odd read address");
	a_read_pulse: assert property (
		mem_re_r |=> !mem_re_r && done_r) else $error("load timing wrong");
	a_push_order: assert property (
		tk && op_code == `OTD_OP_PUSH32 |=> mem_we_r
		&& mem_addr_r == $past(opd_addr) - 16'h2 && mem_wdata_r == $past(hi)
		##1 mem_we_r && done_r && mem_addr_r == $past(opd_addr, 2) - 16'h4
		&& mem_wdata_r == $past(lo, 2)) else $error("push order wrong");
	a_div_time: assert property (
		tk && op_code == `OTD_OP_DIV && opd_wide[31:16] < opd_b
		|=> busy_r[*8] ##1 busy_r[*8] ##1 done_r && !busy_r)
		else $error("divide timing wrong");
	a_above_br: assert property (
		tk && op_code == `OTD_OP_BR_ABOVE |=> branch_r == $past(abv))
		else $error("above branch wrong");
	a_great_br: assert property (
		tk && op_code == `OTD_OP_BR_GREAT |=> branch_r == $past(gtr))
		else $error("greater branch wrong");
endmodule
bind otd_datapath otd_checker i_chk (
	.ref_clk(ref_clk), .rst(rst), .op_start(op_start), .op_code(op_code),
	.is_byte(is_byte), .opd_a(opd_a), .opd_b(opd_b), .opd_wide(opd_wide),
	.opd_addr(opd_addr), .busy_r(busy_r), .done_r(done_r), .result_r(result_r),
	.branch_r(branch_r), .flag_z_r(flag_z_r), .flag_n_r(flag_n_r), .flag_c_r(flag_c_r),
	.flag_v_r(flag_v_r), .flag_vt_r(flag_vt_r), .mem_addr_r(mem_addr_r),
	.mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_re_r(mem_re_r)
);

// ---- test/test_otd_datapath.sv ----
// self-checking testbench of the operand type datapath
`timescale 1ns/100ps
`include "otd_defines.vh"
module test_otd_datapath;
	reg         ref_clk, rst, op_start, is_byte, y;
	reg  [4:0]  op_code, c;
	reg  [15:0] opd_a, opd_b, opd_addr, mem_rdata, a, b, d;
	reg  [31:0] opd_wide, w, e;
	reg  [19:0] f;
	wire        busy_r, done_r, branch_r, align_err_r, mem_we_r, mem_re_r;
	wire        flag_z_r, flag_n_r, flag_c_r, flag_v_r, flag_vt_r, flag_st_r;
	wire [31:0] result_r;
	wire [15:0] mem_addr_r, mem_wdata_r;
	wire [4:0]  norm_cnt_r;
	wire [1:0]  mem_be_r;
	integer     n_fail, checked, i, k;
	otd_datapath i_dut (
		.ref_clk(ref_clk), .rst(rst), .op_start(op_start), .op_code(op_code),
		.is_byte(is_byte), .opd_a(opd_a), .opd_b(opd_b), .opd_wide(opd_wide),
		.opd_addr(opd_addr), .mem_rdata(mem_rdata), .busy_r(busy_r), .done_r(done_r),
		.result_r(result_r), .norm_cnt_r(norm_cnt_r), .branch_r(branch_r),
		.align_err_r(align_err_r), .flag_z_r(flag_z_r), .flag_n_r(flag_n_r),
		.flag_c_r(flag_c_r), .flag_v_r(flag_v_r), .flag_vt_r(flag_vt_r),
		.flag_st_r(flag_st_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
		.mem_be_r(mem_be_r), .mem_we_r(mem_we_r), .mem_re_r(mem_re_r)
	);
// ------
// helpers
// ------
	// 40 mhz clock
	always #12.5 ref_clk = ~ref_clk;
	// byte operands go to the top so one word path yields both flag sets
	function [19:0] alu(input [4:0] c, input y, input [15:0] a, input [15:0] b);
		reg [16:0] r;
		reg        ad, sb;
		begin
			a = y ? a << 8 : a;
			b = y ? b << 8 : b;
			ad = (c == `OTD_OP_ADD);
			sb = (c == `OTD_OP_SUB) || (c == `OTD_OP_COMPARE);
			r = ad ? a + b : c == `OTD_OP_AND ? a & b : c == `OTD_OP_OR ? a | b
				: c == `OTD_OP_XOR ? a ^ b : {1'b0, a} - b;
			alu = {r[15:0] == 16'h0, r[15], ad ? r[16] : sb & ~r[16],
				(ad && a[15] == b[15] || sb && a[15] != b[15]) && r[15] != a[15],
				y ? {8'h00, r[15:8]} : r[15:0]};
		end
	endfunction
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp)
			begin
				n_fail = n_fail + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checked %0d n_fail %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// one request, then a bounded wait for the completion pulse
	task run(input [4:0] c, input y, input [15:0] a, input [15:0] b, input [15:0] d,
		input [31:0] w);
		integer t;
		begin
			@(posedge ref_clk);
			op_start <= 1'b1;
			op_code <= c;
			is_byte <= y;
			opd_a <= a;
			opd_b <= b;
			opd_addr <= d;
			opd_wide <= w;
			mem_rdata <= $urandom;
			@(posedge ref_clk);
			op_start <= 1'b0;
			#1;
			for (t = 0; t < 40 && done_r !== 1'b1; t++)
				@(posedge ref_clk) #1;
			if (t == 40)
			begin
				n_fail = n_fail + 1;
				report_and_stop;
			end
		end
	endtask
// ------
// main sequence
// ------
	initial
	begin
		{ref_clk, op_start, op_code, is_byte, opd_a, opd_b, opd_addr, mem_rdata, opd_wide} = 0;
		rst = 1'b1;
		n_fail = 0;
		checked = 0;
		w = $urandom(32'h0c74);
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		// corners first: word and byte overflow, then random operands
		for (i = 0; i < 60; i++)
		begin
			c = i % 6;
			y = (i < 24) ? i[3] : $urandom;
			a = (i < 24) ? (i[2] ? 16'h8080 : 16'h7fff) : $urandom;
			b = (i < 24) ? 16'h0001 : $urandom;
			run(c, y, a, b, 16'h0, 0);
			f = alu(c, y, a, b);
			check("flags", {flag_z_r, flag_n_r, flag_c_r, flag_v_r}, f[19:16]);
			if (c != `OTD_OP_COMPARE)
				check("value", result_r[15:0], f[15:0]);
			else
			begin
				run(`OTD_OP_BR_ABOVE, 0, a, b, 16'h0, 0);
				check("above", branch_r, y ? a[7:0] > b[7:0] : a > b);
				k = y ? $signed(a[7:0]) > $signed(b[7:0]) : $signed(a) > $signed(b);
				run(`OTD_OP_BR_GREAT, 0, a, b, 16'h0, 0);
				check("great", branch_r, k);
			end
		end
		check("sticky", flag_vt_r, 1);
		$display("arith test done");
		for (i = 0; i < 16; i++)
		begin
			d = $urandom;
			c = (i % 4 == 3) ? `OTD_OP_LD_WORD : `OTD_OP_LD_ZFILL + i % 2;
			a = $urandom;
			run(c, 0, a, 16'h0, d, 0);
			w = d[0] ? mem_rdata[15:8] : mem_rdata[7:0];
			if (c == `OTD_OP_LD_SFILL)
				w[15:8] = {8{w[7]}};
			if (c == `OTD_OP_LD_WORD)
				w = mem_rdata;
			check("load", result_r, w);
			check("place", align_err_r, d[0] && c == `OTD_OP_LD_WORD);
			check("lane", mem_be_r, c == `OTD_OP_LD_WORD ? 2'h3 : d[0] ? 2'h2 : 2'h1);
			check("laddr", mem_addr_r, d & 16'hfffe);
			run(i[0] ? `OTD_OP_WIDEN_SW : `OTD_OP_ZERO_WRD, 0, a, 16'h0, 16'h0, 0);
			check("widen", result_r, {i[0] ? {16{a[15]}} : 16'h0000, a});
		end
		$display("load test done");
		for (i = 0; i < 8; i++)
		begin
			a = $urandom;
			b = $urandom | 16'h8000;
			w = $urandom & 32'h7fffffff;
			run(`OTD_OP_MUL, 0, a, b, 16'h0010, 0);
			check("mul", result_r, {16'h0, a} * {16'h0, b});
			run(`OTD_OP_DIV, 0, 16'h0, b, 16'h0010, w);
			e[15:0] = w / b;
			e[31:16] = w % b;
			check("div", result_r, e);
		end
		run(`OTD_OP_DIV, 0, 16'h0, 16'h0, 16'h0010, w);
		check("div0", flag_v_r, 1);
		check("keep", result_r, e);
		$display("mul div test done");
		for (i = 0; i < 30; i++)
		begin
			c = `OTD_OP_SHL32 + i % 3;
			w = $urandom;
			k = (i < 3) ? 0 : (i < 6) ? 31 : $urandom % 32;
			run(c, 0, 16'h0, k, 16'h0020, w);
			e = (c == `OTD_OP_SHL32) ? w << k : w >> k;
			if (c == `OTD_OP_SRA32)
				e = $signed(w) >>> k;
			check("shift", result_r, e);
			f[0] = k && c != `OTD_OP_SHL32 && |(w & ((32'h1 << (k - 1)) - 32'h1));
			check("resid", flag_st_r, f[0]);
			check("scarry", flag_c_r, k != 0 && (c == `OTD_OP_SHL32 ? w[32 - k] : w[k - 1]));
			w = i ? $urandom >> ($urandom % 32) : 0;
			run(`OTD_OP_NORM, 0, 16'h0, 16'h0, 16'h0040, w);
			for (k = 0; k < 31 && !w[31 - k]; k++);
			check("ncnt", norm_cnt_r, k);
			check("norm", result_r, w << k);
			check("nzero", flag_z_r, w == 0);
		end
		$display("shift test done");
		for (i = 0; i < 16; i++)
		begin
			a = $urandom;
			run(i[0] ? `OTD_OP_BR_BSET : `OTD_OP_BR_BCLR, 0, a, i, 16'h0, 0);
			check("bit", branch_r, a[i] ^ !i[0]);
			d = (i < 2) ? 16'h00f8 + i * 8 : $urandom & 16'h01ff;
			run(`OTD_OP_BLK_CHK, 0, 16'h0, 16'h0, d, 0);
			check("blk", align_err_r, d[2:0] != 0 || d >= 16'h0100);
			run(`OTD_OP_SHR32, 0, 16'h0, 16'h0, d, 0);
			check("dw", align_err_r, d[1:0] != 0 || d >= 16'h0100);
			d = ($urandom & 16'h0ffe) | 16'h0100;
			run(`OTD_OP_PUSH32, 0, 16'h0, 16'h0, d, $urandom);
			check("push", result_r, d - 16'h4);
		end
		$display("bit place test done");
		report_and_stop;
	end
endmodule
